/* ptd_pkg.sv */
// package: topology codes, object kinds, register map and widths for the decomposer
package ptd_pkg;
  localparam int VTX_W = 32;
  localparam int TOPO_W = 4;
  typedef enum logic [3:0] {
    topo_point_list,
    topo_point_list_back,
    topo_line_list,
    topo_line_strip,
    topo_line_strip_continue,
    topo_line_strip_back,
    topo_line_strip_continue_back,
    topo_triangle_list,
    topo_triangle_strip,
    topo_triangle_strip_reversed,
    topo_triangle_fan,
    topo_triangle_fan_unstippled,
    topo_polygon,
    topo_rectangle_list
  } ptd_topo_type;
  typedef enum logic [1:0] {
    obj_point,
    obj_line,
    obj_triangle,
    obj_rectangle
  } ptd_obj_type;
  // register map (byte addresses)
  localparam logic [11:0] ADDR_PROVOKE = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_COUNT   = 12'h008;
  // provoking select fields inside ADDR_PROVOKE
  localparam int LINE_SEL_LSB = 0;
  localparam int TRI_SEL_LSB  = 2;
  localparam int FAN_SEL_LSB  = 4;
  localparam logic [5:0] PROVOKE_RESET = 6'h00;
endpackage

/* ptd_apb_regs.sv */
// APB slave holding the provoking-vertex selects and showing decomposer state
`timescale 1ns/10ps
`default_nettype none
module ptd_apb_regs
  import ptd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        busy,
  input  wire logic [15:0] obj_count,
  output logic      [1:0]  line_sel,
  output logic      [1:0]  tri_sel,
  output logic      [1:0]  fan_sel
);
  logic [5:0]  prov_q;
  logic [5:0]  prov_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        err_q;
  logic        err_d;
  logic        acc;

  // zero wait state: the answer stands in the first access cycle
  assign acc     = psel && !penable;
  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = err_q;
  assign line_sel = prov_q[LINE_SEL_LSB+:2];
  assign tri_sel  = prov_q[TRI_SEL_LSB+:2];
  assign fan_sel  = prov_q[FAN_SEL_LSB+:2];

  always_comb begin
    prov_d  = prov_q;
    rdata_d = rdata_q;
    err_d   = err_q;
    // decode in setup so read data is registered before the access edge
    if (acc) begin
      err_d   = 1'b0;
      rdata_d = 32'h0000_0000;
      unique case (paddr)
        ADDR_PROVOKE: rdata_d = {26'h000_0000, prov_q};
        ADDR_STATUS:  rdata_d = {31'h0000_0000, busy};
        ADDR_COUNT:   rdata_d = {16'h0000, obj_count};
        default:      err_d   = 1'b1;
      endcase
    end
    if (psel && penable && pwrite && paddr == ADDR_PROVOKE) begin
      prov_d = pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prov_q  <= PROVOKE_RESET;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      prov_q  <= prov_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end
endmodule
`default_nettype wire

/* ptd_vertex_window.sv */
// three-entry vertex window with fan anchor
`timescale 1ns/10ps
`default_nettype none
module ptd_vertex_window
  import ptd_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             load,
  input  wire logic             first,
  input  wire logic             clear,
  input  wire logic [VTX_W-1:0] vtx,
  output logic      [VTX_W-1:0] anchor,
  output logic      [VTX_W-1:0] older,
  output logic      [VTX_W-1:0] newer
);
  logic [VTX_W-1:0] anc_q;
  logic [VTX_W-1:0] anc_d;
  logic [VTX_W-1:0] old_q;
  logic [VTX_W-1:0] old_d;
  logic [VTX_W-1:0] new_q;
  logic [VTX_W-1:0] new_d;

  assign anchor = anc_q;
  assign older  = old_q;
  assign newer  = new_q;

  always_comb begin
    anc_d = anc_q;
    old_d = old_q;
    new_d = new_q;
    if (clear) begin
      old_d = '0;
      new_d = '0;
    end else if (load) begin
      if (first) begin
        anc_d = vtx;
      end
      old_d = new_q;
      new_d = vtx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      anc_q <= '0;
      old_q <= '0;
      new_q <= '0;
    end else begin
      anc_q <= anc_d;
      old_q <= old_d;
      new_q <= new_d;
    end
  end
endmodule
`default_nettype wire

/* ptd_decomposer.sv */
// primitive topology decomposer: vertex stream in, basic objects out
// How it works
// - point lists: one vertex object, index zero
// - back point list sets back facing flag
// - line list pairs disjoint vertices
// - line index from line select; lists unstippled-continue
// - line strip shares one vertex per line
// - strip back flag; continue on later lines
// - triangle list disjoint triples, stippled, uninverted
// - list/strip triangle index from triangle select
// - strip triangles from sliding triples, stippled
// - strip winding starts per type, toggles
// - fan keeps vertex zero in every triangle
// - fan winding invert always clear
// - fan index from fan select
// - unstippled fan clears polygon stipple flag
// - polygon is fan with index zero
// - rectangle list like triangle list, index zero, unstippled
// - objects leave one by one in order
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ptd_decomposer
  import ptd_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 vtx_valid,
  output logic                      vtx_ready,
  input  wire logic [VTX_W-1:0]     vtx_data,
  input  wire logic                 vtx_first,
  input  wire logic                 vtx_last,
  input  wire ptd_pkg::ptd_topo_type vtx_topo,
  output logic                      obj_valid,
  input  wire logic                 obj_ready,
  output ptd_pkg::ptd_obj_type      object_kind,
  output logic      [1:0]           object_vertex_count,
  output logic      [VTX_W-1:0]     obj_v0,
  output logic      [VTX_W-1:0]     obj_v1,
  output logic      [VTX_W-1:0]     obj_v2,
  output logic      [1:0]           flat_shade_vertex_index,
  output logic                      back_facing_flag,
  output logic                      stipple_continue_flag,
  output logic                      winding_invert_flag,
  output logic                      polygon_stipple_flag
);
  // ==========================================================
  // registers and window
  // ==========================================================
  logic [1:0]       line_sel;
  logic [1:0]       tri_sel;
  logic [1:0]       fan_sel;
  logic [VTX_W-1:0] anchor;
  logic [VTX_W-1:0] older;
  logic [VTX_W-1:0] newer;
  logic             take;
  logic             busy_q;
  logic             busy_d;
  logic [15:0]      cnt_q;
  logic [15:0]      cnt_d;

  ptd_apb_regs u_regs (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .busy      (busy_q),
    .obj_count (cnt_q),
    .line_sel  (line_sel),
    .tri_sel   (tri_sel),
    .fan_sel   (fan_sel)
  );

  ptd_vertex_window u_win (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (take),
    .first   (vtx_first),
    .clear   (take && vtx_last),
    .vtx     (vtx_data),
    .anchor  (anchor),
    .older   (older),
    .newer   (newer)
  );

  // ==========================================================
  // decomposition state
  // ==========================================================
  // pos_q counts vertices of this primitive (saturating at 3), or of the current object in line, triangle and rectangle lists
  logic [1:0]  pos_q;
  logic [1:0]  pos_d;
  logic        inv_q;
  logic        inv_d;
  logic        cont_q;
  logic        cont_d;
  ptd_topo_type topo_q;
  ptd_topo_type topo_d;
  logic        emit;
  logic [1:0]  pos_now;
  ptd_topo_type topo_now;
  logic        ov_q;
  logic        ov_d;
  ptd_obj_type kind_q;
  ptd_obj_type kind_d;
  logic [1:0]  nv_q;
  logic [1:0]  nv_d;
  logic [VTX_W-1:0] v0_q;
  logic [VTX_W-1:0] v0_d;
  logic [VTX_W-1:0] v1_q;
  logic [VTX_W-1:0] v1_d;
  logic [VTX_W-1:0] v2_q;
  logic [VTX_W-1:0] v2_d;
  logic [1:0]  pv_q;
  logic [1:0]  pv_d;
  logic        bf_q;
  logic        bf_d;
  logic        sc_q;
  logic        sc_d;
  logic        wi_q;
  logic        wi_d;
  logic        ps_q;
  logic        ps_d;

  // one object register; a vertex is taken only when it may be refilled
  assign vtx_ready = !ov_q || obj_ready;
  assign take      = vtx_valid && vtx_ready;
  assign pos_now   = vtx_first ? 2'd0 : pos_q;
  assign topo_now  = vtx_first ? vtx_topo : topo_q;

  assign obj_valid               = ov_q;
  assign object_kind             = kind_q;
  assign object_vertex_count     = nv_q;
  assign obj_v0                  = v0_q;
  assign obj_v1                  = v1_q;
  assign obj_v2                  = v2_q;
  assign flat_shade_vertex_index = pv_q;
  assign back_facing_flag        = bf_q;
  assign stipple_continue_flag   = sc_q;
  assign winding_invert_flag     = wi_q;
  assign polygon_stipple_flag    = ps_q;

  always_comb begin
    pos_d  = pos_q;
    inv_d  = inv_q;
    cont_d = cont_q;
    topo_d = topo_q;
    busy_d = busy_q;
    cnt_d  = cnt_q;
    ov_d   = ov_q && !obj_ready;
    kind_d = kind_q;
    nv_d   = nv_q;
    v0_d   = v0_q;
    v1_d   = v1_q;
    v2_d   = v2_q;
    pv_d   = pv_q;
    bf_d   = bf_q;
    sc_d   = sc_q;
    wi_d   = wi_q;
    ps_d   = ps_q;
    emit   = 1'b0;
    if (take) begin
      topo_d = topo_now;
      busy_d = !vtx_last;
      if (vtx_first) begin
        inv_d  = (vtx_topo == topo_triangle_strip_reversed);
        cont_d = (vtx_topo == topo_line_strip_continue) ||
                 (vtx_topo == topo_line_strip_continue_back);
      end
      pos_d = (pos_now == 2'd3) ? 2'd3 : pos_now + 2'd1;
      v0_d  = newer;
      v1_d  = vtx_data;
      v2_d  = vtx_data;
      bf_d  = 1'b0;
      sc_d  = 1'b0;
      wi_d  = 1'b0;
      ps_d  = 1'b1;
      pv_d  = 2'd0;
      unique case (topo_now)
        topo_point_list, topo_point_list_back: begin
          emit   = 1'b1;
          kind_d = obj_point;
          nv_d   = 2'd1;
          v0_d   = vtx_data;
          bf_d   = (topo_now == topo_point_list_back);
          ps_d   = 1'b0;
        end
        topo_line_list: begin
          emit   = pos_now[0];
          pos_d  = {1'b0, ~pos_now[0]};
          kind_d = obj_line;
          nv_d   = 2'd2;
          pv_d   = line_sel;
          ps_d   = 1'b0;
        end
        topo_line_strip, topo_line_strip_continue,
        topo_line_strip_back, topo_line_strip_continue_back: begin
          emit   = (pos_now != 2'd0);
          kind_d = obj_line;
          nv_d   = 2'd2;
          pv_d   = line_sel;
          ps_d   = 1'b0;
          bf_d   = (topo_now == topo_line_strip_back) ||
                   (topo_now == topo_line_strip_continue_back);
          sc_d   = vtx_first ? 1'b0 : cont_q;
          if (emit) begin
            cont_d = 1'b1;
          end
        end
        topo_triangle_list, topo_rectangle_list: begin
          emit   = (pos_now == 2'd2);
          pos_d  = (pos_now == 2'd2) ? 2'd0 : pos_now + 2'd1;
          kind_d = (topo_now == topo_rectangle_list) ? obj_rectangle : obj_triangle;
          nv_d   = 2'd3;
          v0_d   = older;
          v1_d   = newer;
          pv_d   = (topo_now == topo_rectangle_list) ? 2'd0 : tri_sel;
          ps_d   = (topo_now == topo_triangle_list);
        end
        topo_triangle_strip, topo_triangle_strip_reversed: begin
          emit   = (pos_now >= 2'd2);
          kind_d = obj_triangle;
          nv_d   = 2'd3;
          v0_d   = older;
          v1_d   = newer;
          pv_d   = tri_sel;
          wi_d   = vtx_first ? inv_d : inv_q;
          if (emit) begin
            inv_d = !wi_d;
          end
        end
        topo_triangle_fan, topo_triangle_fan_unstippled, topo_polygon: begin
          emit   = (pos_now >= 2'd2);
          kind_d = obj_triangle;
          nv_d   = 2'd3;
          v0_d   = anchor;
          v1_d   = newer;
          wi_d   = 1'b0;
          pv_d   = (topo_now == topo_polygon) ? 2'd0 : fan_sel;
          ps_d   = (topo_now != topo_triangle_fan_unstippled);
        end
        default: begin
          emit = 1'b0;
        end
      endcase
      if (emit) begin
        ov_d  = 1'b1;
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q  <= 2'd0;
      inv_q  <= 1'b0;
      cont_q <= 1'b0;
      topo_q <= topo_point_list;
      busy_q <= 1'b0;
      cnt_q  <= 16'h0000;
      ov_q   <= 1'b0;
      kind_q <= obj_point;
      nv_q   <= 2'd0;
      v0_q   <= '0;
      v1_q   <= '0;
      v2_q   <= '0;
      pv_q   <= 2'd0;
      bf_q   <= 1'b0;
      sc_q   <= 1'b0;
      wi_q   <= 1'b0;
      ps_q   <= 1'b0;
    end else begin
      pos_q  <= pos_d;
      inv_q  <= inv_d;
      cont_q <= cont_d;
      topo_q <= topo_d;
      busy_q <= busy_d;
      cnt_q  <= cnt_d;
      ov_q   <= ov_d;
      kind_q <= kind_d;
      nv_q   <= nv_d;
      v0_q   <= v0_d;
      v1_q   <= v1_d;
      v2_q   <= v2_d;
      pv_q   <= pv_d;
      bf_q   <= bf_d;
      sc_q   <= sc_d;
      wi_q   <= wi_d;
      ps_q   <= ps_d;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  hold_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
    obj_valid && !obj_ready |=> obj_valid && $stable(obj_v0) && $stable(obj_v1))
    else $error("object changed while stalled");
  no_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    obj_valid && !obj_ready |=> $stable(pos_q) && $stable(topo_q) && $stable(obj_v2))
    else $error("intake open while output blocked");
  point_shape_a: assert property (@(posedge pclk) disable iff (!presetn)
    obj_valid && object_kind == obj_point |-> object_vertex_count == 2'd1
      && flat_shade_vertex_index == 2'd0)
    else $error("bad point object");
  point_back_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && vtx_topo == topo_point_list_back && vtx_first |=> obj_valid && back_facing_flag)
    else $error("back point not flagged");
  list_stipple_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && topo_now == topo_line_list && pos_now[0] |=> !stipple_continue_flag
      && flat_shade_vertex_index == $past(line_sel))
    else $error("line list flags wrong");
  strip_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && topo_now == topo_line_strip && pos_now != 2'd0 |=> obj_v0 == $past(newer)
      && obj_v1 == $past(vtx_data))
    else $error("strip line vertices wrong");
  strip_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && emit && topo_now == topo_triangle_strip && pos_now == 2'd3
      |=> winding_invert_flag != $past(winding_invert_flag))
    else $error("strip winding wrong");
  fan_anchor_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && emit && topo_now == topo_triangle_fan |=> obj_v0 == $past(anchor)
      && !winding_invert_flag)
    else $error("fan anchor lost");
  poly_index_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && emit && topo_now == topo_polygon |=> flat_shade_vertex_index == 2'd0)
    else $error("polygon index not zero");
  rect_kind_a: assert property (@(posedge pclk) disable iff (!presetn)
    take && emit && topo_now == topo_rectangle_list |=> object_kind == obj_rectangle
      && !winding_invert_flag && flat_shade_vertex_index == 2'd0)
    else $error("rectangle object wrong");
endmodule
`default_nettype wire

/* ptd_sink_model.sv */
// object setup stand-in: takes decomposed objects, promptly or with random stalls
`timescale 1ns/10ps
`default_nettype none
module ptd_sink_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  output logic      obj_ready
);
  // ==========================================
  // acceptance
  // slow mode takes about one object in four, so intake must stall behind it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obj_ready <= 1'b0;
    end else begin
      obj_ready <= slow ? ($urandom_range(3) == 0) : 1'b1;
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the topology decomposer
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ptd_pkg::*;
  typedef struct packed {
    ptd_obj_type      kind;
    logic [1:0]       cnt;
    logic [VTX_W-1:0] v0, v1, v2;
    logic [1:0]       idx;
    logic             bf, sc, wi, ps;
  } ptd_exp_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic vtx_valid, vtx_ready, vtx_first, vtx_last, obj_valid, obj_ready;
  logic bf, sc, wi, ps, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [VTX_W-1:0] vtx_data, v0, v1, v2;
  logic [1:0] cnt, idx;
  logic [5:0] sel;
  ptd_topo_type vtx_topo;
  ptd_obj_type kind;
  ptd_exp_type exp_q[$];
  int n_errors, cmp_count, n_obj, m, t, i;
  ptd_decomposer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vtx_valid(vtx_valid), .vtx_ready(vtx_ready), .vtx_data(vtx_data),
    .vtx_first(vtx_first), .vtx_last(vtx_last), .vtx_topo(vtx_topo), .obj_valid(obj_valid),
    .obj_ready(obj_ready), .object_kind(kind), .object_vertex_count(cnt), .obj_v0(v0),
    .obj_v1(v1), .obj_v2(v2), .flat_shade_vertex_index(idx), .back_facing_flag(bf),
    .stipple_continue_flag(sc), .winding_invert_flag(wi), .polygon_stipple_flag(ps));
  ptd_sink_model sink (.pclk(pclk), .presetn(presetn), .slow(slow), .obj_ready(obj_ready));
  // ==========================================
  // reporting
  task automatic fail(input string s);
    n_errors++;
    $display("wrong value at %0t: %s", $time, s);
  endtask
  task automatic chk(input logic c, input string s);
    cmp_count++;
    if (c !== 1'b1) fail(s);
  endtask
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================
  // apb master: called right after a rising edge, returns one idle cycle later
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // the request stands until the edge that samples pready high; data is taken there
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0; pwdata <= ~d;
    @(posedge pclk);
  endtask
  // ==========================================
  // vertex source; expectations are noted as each vertex is taken
  task automatic send_prim(input int tp, input int n, input logic [5:0] s);
    logic [VTX_W-1:0] d[$];
    logic [VTX_W-1:0] x;
    ptd_exp_type q;
    logic emit;
    for (int k = 0; k < n; k++) begin
      x = $urandom;
      d.push_back(x);
      vtx_valid <= 1'b1; vtx_data <= x; vtx_topo <= ptd_topo_type'(tp);
      vtx_first <= (k == 0); vtx_last <= (k == n - 1);
      @(negedge pclk);
      while (vtx_ready !== 1'b1) begin
        @(posedge pclk);
        @(negedge pclk);
      end
      @(posedge pclk);
      q = '0; q.v0 = d[k]; q.v1 = d[k]; q.v2 = d[k]; q.cnt = 2'd3; q.kind = obj_triangle;
      emit = 1'b0;
      case (tp)
        0, 1: begin
          q.kind = obj_point; q.cnt = 2'd1; q.bf = (tp == 1); emit = 1'b1;
        end
        2: if (k % 2 == 1) begin
          q.kind = obj_line; q.cnt = 2'd2; q.v0 = d[k-1]; q.idx = s[1:0]; emit = 1'b1;
        end
        3, 4, 5, 6: if (k > 0) begin
          q.kind = obj_line; q.cnt = 2'd2; q.v0 = d[k-1]; q.idx = s[1:0];
          q.bf = (tp >= 5); q.sc = (tp == 4 || tp == 6 || k > 1); emit = 1'b1;
        end
        7, 13: if (k % 3 == 2) begin
          q.kind = (tp == 7) ? obj_triangle : obj_rectangle; q.ps = 1'b1;
          q.v0 = d[k-2]; q.v1 = d[k-1]; q.idx = (tp == 7) ? s[3:2] : 2'd0; emit = 1'b1;
        end
        8, 9: if (k > 1) begin
          q.v0 = d[k-2]; q.v1 = d[k-1]; q.idx = s[3:2]; q.ps = 1'b1;
          q.wi = (tp == 9) ^ (k % 2 == 1); emit = 1'b1;
        end
        default: if (k > 1) begin
          q.v0 = d[0]; q.v1 = d[k-1]; q.ps = (tp != 11); emit = 1'b1;
          q.idx = (tp == 12) ? 2'd0 : s[5:4];
        end
      endcase
      if (emit) begin
        exp_q.push_back(q);
        n_obj++;
      end
    end
    vtx_valid <= 1'b0; vtx_data <= ~x; vtx_first <= 1'b0; vtx_last <= 1'b0;
    @(posedge pclk);
  endtask
  // ==========================================
  // object monitor: a handshake is judged at the low phase before its edge
  always @(negedge pclk) begin
    if (presetn === 1'b1 && obj_valid === 1'b1 && obj_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail("object with none expected");
      end else begin
        cmp_count++;
        if (kind !== exp_q[0].kind || cnt !== exp_q[0].cnt || v0 !== exp_q[0].v0) fail("kind");
        if (idx !== exp_q[0].idx) fail("provoking index");
        if (kind != obj_point && v1 !== exp_q[0].v1) fail("second vertex");
        if (cnt == 2'd3 && (v2 !== exp_q[0].v2 || wi !== exp_q[0].wi)) fail("tri");
        if (kind <= obj_line && bf !== exp_q[0].bf) fail("back facing");
        if (kind == obj_line && sc !== exp_q[0].sc) fail("stipple continue");
        if (kind == obj_triangle && ps !== exp_q[0].ps) fail("polygon stipple");
        void'(exp_q.pop_front());
      end
    end
  end
  // ==========================================
  // clock, watchdog, main sequence
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #200000;
    fail("timeout");
    print_verdict();
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; vtx_valid = 1'b0; vtx_data = '0; vtx_first = 1'b0; vtx_last = 1'b0;
    vtx_topo = topo_point_list; slow = 1'b0; n_errors = 0; cmp_count = 0; n_obj = 0;
    void'($urandom(32'h636D));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_PROVOKE, 32'h0);
    chk(r === {26'h0, PROVOKE_RESET} && e === 1'b0, "select reset value");
    apb(1'b0, 12'h00C, 32'h0);
    chk(r === 32'h0 && e === 1'b1, "unmapped read");
    // six vertices fit every topology's count restriction
    for (m = 0; m < 2; m++) begin
      for (t = 0; t < 14; t++) begin
        slow <= m[0];
        sel = {2'($urandom % 3), 2'($urandom % 3), 2'($urandom % 2)};
        apb(1'b1, ADDR_PROVOKE, {26'h0, sel});
        apb(1'b0, ADDR_PROVOKE, 32'h0);
        chk(r[5:0] === sel, "select readback");
        send_prim(t, 6, sel);
      end
    end
    for (i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge pclk);
    chk(exp_q.size() == 0, "objects missing");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[0] === 1'b0, "idle status");
    apb(1'b0, ADDR_COUNT, 32'h0);
    chk(r[15:0] === n_obj[15:0], "object count");
    print_verdict();
  end
endmodule
`default_nettype wire
